// File: logic/dwac_defs.vh
// Purpose: constants for the data word area access control block
// Assumes: word addresses are 13 bits, data words are 16 bits
// Notes: all bounds are word indexes, decimal values shown in hex
//
// Function
// - Every access to data or extended memory moves one whole word, never a part of one.
// - Words 0 to 3071 (small variants) or 0 to 6143 (large variants) are free to read and write by both requesters.
// - Words 6144 to 6568 are read-only for instructions but readable and writable by the programming device.
// - With write-protect switch position 1 on, programming-device writes to words 6144 to 6568 are refused.
// - Link parameters, routing table and serial settings inside the read-only region keep its permissions.
// - Hardware logs up to ten errors into words 6569 to 6599, which both requesters may read but not write.
// - The setup block at words 6600 to 6655 is readable by both but writable only by the programming device.
// - The extended area of words 0 to 6143 exists only on the largest variant, one bank, free to both.
// - Read-only region, setup block, program and instruction assignments move to or from the cassette as one unit.
// - A fitted cassette is copied into the CPU at startup so that a failed backup battery does not matter.
// - Smaller variants accept cassette data from the largest, with extended-area programs not guaranteed.
`ifndef DWAC_DEFS_VH
`define DWAC_DEFS_VH
`define DWAC_AW 13
`define DWAC_DW 16
`define DWAC_FREE_SMALL_LAST 13'h0BFF
`define DWAC_FREE_LARGE_LAST 13'h17FF
`define DWAC_RO_FIRST 13'h1800
`define DWAC_RO_LAST 13'h19A8
`define DWAC_LINK_FIRST 13'h1900
`define DWAC_LINK_LAST 13'h1909
`define DWAC_ROUTE_FIRST 13'h1932
`define DWAC_ROUTE_LAST 13'h1953
`define DWAC_SERIAL_FIRST 13'h1966
`define DWAC_SERIAL_LAST 13'h196F
`define DWAC_LOG_FIRST 13'h19A9
`define DWAC_LOG_LAST 13'h19C7
`define DWAC_SETUP_FIRST 13'h19C8
`define DWAC_SETUP_LAST 13'h19FF
`define DWAC_EXT_LAST 13'h17FF
`define DWAC_LOG_ENTRIES 4'hA
`define DWAC_LOG_WORDS 3'h3
`define DWAC_VAR_SMALL 2'h0
`define DWAC_VAR_LARGE 2'h1
`define DWAC_VAR_LARGEST 2'h2
`define DWAC_PROG_WORDS 13'h0100
`define DWAC_ASGN_WORDS 13'h0010
`define DWAC_RO_WORDS 13'h01A9
`define DWAC_DM_IMG_WORDS 13'h01E1
`define DWAC_SYNC_WAIT 13'h0002
`endif

// File: logic/dwac_region.v
// Purpose: classify a word address and a requester into access rights
// Assumes: pure combinational logic on same-clock inputs
// Notes: bounds come from the defs header
`timescale 1ns/10ps
`include "dwac_defs.vh"
module dwac_region (
  // Request
  input wire [`DWAC_AW-1:0] addr,
  input wire ext_sel,
  input wire from_device,
  input wire [1:0] variant,
  input wire protect_on,
  // Rights
  output reg rd_ok,
  output reg wr_ok
);
  always @* begin
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    if (ext_sel) begin
      if (variant == `DWAC_VAR_LARGEST && addr <= `DWAC_EXT_LAST) begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
      end
    end else if (addr <= `DWAC_FREE_SMALL_LAST ||
                 (variant != `DWAC_VAR_SMALL && addr <= `DWAC_FREE_LARGE_LAST)) begin
      rd_ok = 1'b1;
      wr_ok = 1'b1;
    end else if (addr >= `DWAC_RO_FIRST && addr <= `DWAC_RO_LAST) begin
      // Sub-regions share these rights
      rd_ok = 1'b1;
      wr_ok = from_device & ~protect_on;
    end else if (addr >= `DWAC_LOG_FIRST && addr <= `DWAC_LOG_LAST) begin
      rd_ok = 1'b1;
    end else if (addr >= `DWAC_SETUP_FIRST && addr <= `DWAC_SETUP_LAST) begin
      rd_ok = 1'b1;
      wr_ok = from_device;
    end
  end
endmodule

// File: logic/dwac_top.v
// Purpose: access control and storage for data and extended memory words
// Assumes: two requesters, instructions and programming device, one word per access
// Notes: cassette holds an image of protected words, program and assignments
`timescale 1ns/10ps
`include "dwac_defs.vh"
module dwac_top #(
  parameter [1:0] VARIANT = `DWAC_VAR_LARGEST
) (
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // Instruction port
  input wire ins_req,
  input wire ins_we,
  input wire ins_ext,
  input wire [`DWAC_AW-1:0] ins_addr,
  input wire [`DWAC_DW-1:0] ins_wdata,
  output reg ins_ack,
  output reg ins_err,
  output reg [`DWAC_DW-1:0] ins_rdata,
  // Programming device port
  input wire dev_req,
  input wire dev_we,
  input wire dev_ext,
  input wire [`DWAC_AW-1:0] dev_addr,
  input wire [`DWAC_DW-1:0] dev_wdata,
  output reg dev_ack,
  output reg dev_err,
  output reg [`DWAC_DW-1:0] dev_rdata,
  // Front switch pin
  input wire protect_pin,
  // Error logger
  input wire log_req,
  input wire [`DWAC_DW-1:0] log_code,
  input wire [`DWAC_DW-1:0] log_date,
  input wire [`DWAC_DW-1:0] log_time,
  // Program and assignment store
  input wire prog_we,
  input wire [`DWAC_AW-1:0] prog_addr,
  input wire [`DWAC_DW-1:0] prog_wdata,
  output reg [`DWAC_DW-1:0] prog_rdata,
  // Cassette
  input wire cas_present,
  input wire cas_save,
  output reg cas_busy,
  output reg cas_done,
  output reg cas_ext_warn
);
  localparam IDLE = 2'h0;
  localparam LOAD = 2'h1;
  localparam SAVE = 2'h2;
  localparam BOOT = 2'h3;

  reg [`DWAC_DW-1:0] dm_mem [0:8191];
  reg [`DWAC_DW-1:0] em_mem [0:6143];
  // Program words first, then assignments, no aliasing
  reg [`DWAC_DW-1:0] prg_mem [0:271];
  reg [`DWAC_DW-1:0] cas_mem [0:2047];
  reg cas_ext_used_reg;

  reg prot_s1_reg, prot_s2_reg;
  reg pres_s1_reg, pres_s2_reg;
  reg [1:0] state_reg;
  reg [12:0] cnt_reg;
  reg [3:0] log_idx_reg;
  reg [1:0] log_ph_reg;
  reg log_busy_reg;
  reg [`DWAC_DW-1:0] log_c_reg, log_d_reg, log_t_reg;
  reg ext_written_reg;

  wire ins_rd_ok, ins_wr_ok, dev_rd_ok, dev_wr_ok;
  wire cas_active = (state_reg != IDLE);

  // Synchronise switch and presence pins
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prot_s1_reg <= 1'b0;
      prot_s2_reg <= 1'b0;
      pres_s1_reg <= 1'b0;
      pres_s2_reg <= 1'b0;
    end else begin
      prot_s1_reg <= protect_pin;
      prot_s2_reg <= prot_s1_reg;
      pres_s1_reg <= cas_present;
      pres_s2_reg <= pres_s1_reg;
    end
  end

  dwac_region u_ins_region (
    .addr(ins_addr),
    .ext_sel(ins_ext),
    .from_device(1'b0),
    .variant(VARIANT),
    .protect_on(prot_s2_reg),
    .rd_ok(ins_rd_ok),
    .wr_ok(ins_wr_ok)
  );

  dwac_region u_dev_region (
    .addr(dev_addr),
    .ext_sel(dev_ext),
    .from_device(1'b1),
    .variant(VARIANT),
    .protect_on(prot_s2_reg),
    .rd_ok(dev_rd_ok),
    .wr_ok(dev_wr_ok)
  );

  // Cassette image index mapping
  function [12:0] cas_dm_addr;
    input [12:0] idx;
    begin
      if (idx < `DWAC_RO_WORDS)
        cas_dm_addr = `DWAC_RO_FIRST + idx;
      else
        cas_dm_addr = `DWAC_SETUP_FIRST + (idx - `DWAC_RO_WORDS);
    end
  endfunction

  localparam [12:0] DM_IMG = `DWAC_DM_IMG_WORDS;
  localparam [12:0] IMG_LAST = DM_IMG + `DWAC_PROG_WORDS + `DWAC_ASGN_WORDS - 13'h0001;
  localparam [12:0] PRG_WORDS = `DWAC_PROG_WORDS + `DWAC_ASGN_WORDS;

  wire [12:0] img_off = cnt_reg - DM_IMG;
  wire prog_in_range = (prog_addr < PRG_WORDS);

  wire ins_go = ins_req & ~cas_active;
  wire dev_go = dev_req & ~cas_active;
  wire ins_wr = ins_go & ins_we & ins_wr_ok;
  wire dev_wr = dev_go & dev_we & dev_wr_ok;
  wire [12:0] log_addr = `DWAC_LOG_FIRST + {7'h00, log_idx_reg, 2'h0} - {9'h000, log_idx_reg}
    + {11'h000, log_ph_reg};

  // Memory arrays, one word per access
  always @(posedge core_clk) begin
    if (state_reg == LOAD) begin
      if (cnt_reg < DM_IMG)
        dm_mem[cas_dm_addr(cnt_reg)] <= cas_mem[cnt_reg[10:0]];
      else
        prg_mem[img_off[8:0]] <= cas_mem[cnt_reg[10:0]];
    end else if (state_reg == SAVE) begin
      if (cnt_reg < DM_IMG)
        cas_mem[cnt_reg[10:0]] <= dm_mem[cas_dm_addr(cnt_reg)];
      else
        cas_mem[cnt_reg[10:0]] <= prg_mem[img_off[8:0]];
    end else begin
      if (dev_wr && !dev_ext)
        dm_mem[dev_addr] <= dev_wdata;
      else if (dev_wr)
        em_mem[dev_addr] <= dev_wdata;
      if (ins_wr && !ins_ext && !(dev_wr && !dev_ext && dev_addr == ins_addr))
        dm_mem[ins_addr] <= ins_wdata;
      else if (ins_wr && ins_ext && !(dev_wr && dev_ext && dev_addr == ins_addr))
        em_mem[ins_addr] <= ins_wdata;
      if (log_busy_reg)
        dm_mem[log_addr] <= (log_ph_reg == 2'h0) ? log_c_reg :
          (log_ph_reg == 2'h1) ? log_d_reg : log_t_reg;
      if (prog_we && prog_in_range)
        prg_mem[prog_addr[8:0]] <= prog_wdata;
    end
  end

  // Request answers, one cycle after the request
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ins_ack <= 1'b0;
      ins_err <= 1'b0;
      ins_rdata <= 16'h0000;
      dev_ack <= 1'b0;
      dev_err <= 1'b0;
      dev_rdata <= 16'h0000;
      prog_rdata <= 16'h0000;
    end else begin
      ins_ack <= ins_go;
      ins_err <= ins_go & (ins_we ? ~ins_wr_ok : ~ins_rd_ok);
      dev_ack <= dev_go;
      dev_err <= dev_go & (dev_we ? ~dev_wr_ok : ~dev_rd_ok);
      prog_rdata <= prog_in_range ? prg_mem[prog_addr[8:0]] : 16'h0000;
      if (ins_go && !ins_we)
        ins_rdata <= !ins_rd_ok ? 16'h0000 : ins_ext ? em_mem[ins_addr] : dm_mem[ins_addr];
      if (dev_go && !dev_we)
        dev_rdata <= !dev_rd_ok ? 16'h0000 : dev_ext ? em_mem[dev_addr] : dm_mem[dev_addr];
    end
  end

  // Error log writer, ten entries of three words
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      log_idx_reg <= 4'h0;
      log_ph_reg <= 2'h0;
      log_busy_reg <= 1'b0;
      log_c_reg <= 16'h0000;
      log_d_reg <= 16'h0000;
      log_t_reg <= 16'h0000;
    end else if (log_busy_reg) begin
      if (!cas_active) begin
        if (log_ph_reg == `DWAC_LOG_WORDS - 3'h1) begin
          log_ph_reg <= 2'h0;
          log_busy_reg <= 1'b0;
          log_idx_reg <= (log_idx_reg == `DWAC_LOG_ENTRIES - 4'h1) ? 4'h0 :
            log_idx_reg + 4'h1;
        end else begin
          log_ph_reg <= log_ph_reg + 2'h1;
        end
      end
    end else if (log_req) begin
      log_busy_reg <= 1'b1;
      log_c_reg <= log_code;
      log_d_reg <= log_date;
      log_t_reg <= log_time;
    end
  end

  // Track extended area use for the cassette warning
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      ext_written_reg <= 1'b0;
    else if ((ins_wr && ins_ext) || (dev_wr && dev_ext))
      ext_written_reg <= 1'b1;
  end

  // Cassette transfer sequencer
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= BOOT;
      cnt_reg <= 13'h0000;
      cas_busy <= 1'b1;
      cas_done <= 1'b0;
      cas_ext_warn <= 1'b0;
      cas_ext_used_reg <= 1'b0;
    end else begin
      cas_done <= 1'b0;
      case (state_reg)
        BOOT: begin
          // Let the presence synchroniser fill before deciding
          if (cnt_reg != `DWAC_SYNC_WAIT) begin
            cnt_reg <= cnt_reg + 13'h0001;
          end else if (!pres_s2_reg) begin
            cnt_reg <= 13'h0000;
            state_reg <= IDLE;
            cas_busy <= 1'b0;
          end else begin
            cnt_reg <= 13'h0000;
            state_reg <= LOAD;
          end
        end
        LOAD: begin
          if (cnt_reg == IMG_LAST) begin
            cnt_reg <= 13'h0000;
            state_reg <= IDLE;
            cas_busy <= 1'b0;
            cas_done <= 1'b1;
            // Accepted anyway on small variants
            cas_ext_warn <= cas_ext_used_reg & (VARIANT != `DWAC_VAR_LARGEST);
          end else begin
            cnt_reg <= cnt_reg + 13'h0001;
          end
        end
        SAVE: begin
          if (cnt_reg == IMG_LAST) begin
            cnt_reg <= 13'h0000;
            state_reg <= IDLE;
            cas_busy <= 1'b0;
            cas_done <= 1'b1;
            cas_ext_used_reg <= ext_written_reg;
          end else begin
            cnt_reg <= cnt_reg + 13'h0001;
          end
        end
        IDLE: begin
          if (cas_save && pres_s2_reg && !log_busy_reg) begin
            state_reg <= SAVE;
            cas_busy <= 1'b1;
          end
        end
        default: state_reg <= IDLE;
      endcase
    end
  end
endmodule

// File: test/data_word_area_access_control_test.sv
// Purpose: self-checking bench for dwac_top
// Assumes: largest variant, no cassette at first boot, cassette fitted later
// Notes: last scenario saves, resets mid-run and reloads from the cassette
`timescale 1ns/10ps
module data_word_area_access_control_test;
  localparam logic H = 1'b1, L = 1'b0;
  localparam logic [15:0] Z = 16'h0000;
  reg core_clk = 0, reset_n = 0, protect_pin = 0, log_req = 0, cas_save = 0;
  reg cas_present = 1'b0, prog_we = 1'b0;
  reg [12:0] prog_addr = 13'h0000;
  reg [15:0] log_code = 16'h0000, log_date = 16'h0000, log_time = 16'h0000;
  reg [15:0] prog_wdata = 16'h0000;
  wire cas_ext_warn;
  wire [15:0] prog_rdata;
  wire ins_req, ins_we, ins_ext, ins_ack, ins_err, dev_req, dev_we, dev_ext, dev_ack, dev_err;
  wire cas_busy, cas_done;
  wire [12:0] ins_addr, dev_addr;
  wire [15:0] ins_wdata, ins_rdata, dev_wdata, dev_rdata;
  integer error_cnt = 0, n_tests = 0, cyc = 0, n;
  dwac_top dut (.core_clk(core_clk), .reset_n(reset_n), .ins_req(ins_req), .ins_we(ins_we),
    .ins_ext(ins_ext), .ins_addr(ins_addr), .ins_wdata(ins_wdata), .ins_ack(ins_ack),
    .ins_err(ins_err), .ins_rdata(ins_rdata), .dev_req(dev_req), .dev_we(dev_we),
    .dev_ext(dev_ext), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_ack(dev_ack),
    .dev_err(dev_err), .dev_rdata(dev_rdata), .protect_pin(protect_pin), .log_req(log_req),
    .log_code(log_code), .log_date(log_date), .log_time(log_time), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata),
    .cas_present(cas_present), .cas_save(cas_save), .cas_busy(cas_busy),
    .cas_done(cas_done), .cas_ext_warn(cas_ext_warn));
  dwac_req_model u_ins (.core_clk(core_clk), .req(ins_req), .we(ins_we), .ext(ins_ext),
    .addr(ins_addr), .wdata(ins_wdata), .ack(ins_ack), .err(ins_err), .rdata(ins_rdata));
  dwac_req_model u_dev (.core_clk(core_clk), .req(dev_req), .we(dev_we), .ext(dev_ext),
    .addr(dev_addr), .wdata(dev_wdata), .ack(dev_ack), .err(dev_err), .rdata(dev_rdata));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  end
  task check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task xfer(input logic dv, w, x, input logic [12:0] a, input logic [15:0] d,
    input logic e_err, input logic [15:0] e_rd);
    logic k, e;
    logic [15:0] q;
    if (dv) u_dev.acc(w, x, a, d, k, e, q);
    else u_ins.acc(w, x, a, d, k, e, q);
    check("ack", 16'h0001, {15'h0000, k});
    check("err", {15'h0000, e_err}, {15'h0000, e});
    if (!w && !e_err) check("rdata", e_rd, q);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task t_free;
    xfer(L, H, L, 13'h0000, 16'hA5A5, L, Z);
    xfer(H, H, L, 13'h17FF, 16'h5A5A, L, Z);
    xfer(H, L, L, 13'h0000, Z, L, 16'hA5A5);
    xfer(L, L, L, 13'h17FF, Z, L, 16'h5A5A);
    xfer(L, H, H, 13'h17FF, 16'h1234, L, Z);
    xfer(H, L, H, 13'h17FF, Z, L, 16'h1234);
  endtask
  task t_ro;
    xfer(H, H, L, 13'h1800, 16'h1111, L, Z);
    xfer(H, H, L, 13'h1801, 16'h2222, L, Z);
    xfer(H, H, L, 13'h1900, 16'h3333, L, Z);
    xfer(L, H, L, 13'h1800, 16'hFFFF, H, Z);
    xfer(L, H, L, 13'h1900, 16'hFFFF, H, Z);
    xfer(L, L, L, 13'h1800, Z, L, 16'h1111);
    xfer(L, L, L, 13'h1801, Z, L, 16'h2222);
    xfer(H, L, L, 13'h1900, Z, L, 16'h3333);
  endtask
  task t_log;
    xfer(H, H, L, 13'h19A9, 16'hFFFF, H, Z);
    xfer(L, H, L, 13'h19C7, 16'hFFFF, H, Z);
    @(posedge core_clk) begin
      log_req <= 1'b1;
      log_code <= 16'h0E01;
      log_date <= 16'h0D02;
      log_time <= 16'h0C03;
    end
    @(posedge core_clk) log_req <= 1'b0;
    repeat (4) @(posedge core_clk);
    xfer(L, L, L, 13'h19A9, Z, L, 16'h0E01);
    xfer(H, L, L, 13'h19AB, Z, L, 16'h0C03);
  endtask
  task t_setup;
    xfer(L, H, L, 13'h19C8, 16'hFFFF, H, Z);
    xfer(H, H, L, 13'h19FF, 16'h4444, L, Z);
    xfer(L, L, L, 13'h19FF, Z, L, 16'h4444);
  endtask
  task t_protect;
    @(posedge core_clk) protect_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    xfer(H, H, L, 13'h19A8, 16'h7777, H, Z);
    xfer(H, H, L, 13'h1800, 16'h7777, H, Z);
    xfer(H, L, L, 13'h1800, Z, L, 16'h1111);
    xfer(H, H, L, 13'h0010, 16'h8888, L, Z);
    @(posedge core_clk) protect_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
    xfer(H, H, L, 13'h19A8, 16'h7777, L, Z);
  endtask
  task wait_done;
    for (n = 0; n < 2000 && cas_done !== 1'b1; n = n + 1) @(posedge core_clk) #1;
    check("cas_done", 16'h0001, {15'h0000, cas_done});
  endtask
  task t_cas;
    @(posedge core_clk) begin
      cas_present <= 1'b1;
      prog_we <= 1'b1;
      prog_addr <= 13'h0005;
      prog_wdata <= 16'hBEEF;
    end
    @(posedge core_clk) prog_we <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(posedge core_clk) cas_save <= 1'b1;
    @(posedge core_clk) cas_save <= 1'b0;
    wait_done;
    xfer(H, H, L, 13'h1800, 16'h9999, L, Z);
    xfer(H, H, L, 13'h19FF, 16'h6666, L, Z);
    @(posedge core_clk) begin
      prog_we <= 1'b1;
      prog_wdata <= 16'h0000;
    end
    @(posedge core_clk) begin
      prog_we <= 1'b0;
      reset_n <= 1'b0;
    end
    repeat (3) @(posedge core_clk);
    @(posedge core_clk) reset_n <= 1'b1;
    wait_done;
    check("cas_ext_warn", Z, {15'h0000, cas_ext_warn});
    check("prog_rdata", 16'hBEEF, prog_rdata);
    xfer(H, L, L, 13'h1800, Z, L, 16'h1111);
    xfer(L, L, L, 13'h19FF, Z, L, 16'h4444);
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    for (n = 0; n < 2000 && cas_busy !== 1'b0; n = n + 1) @(posedge core_clk) #1;
    t_free;
    t_ro;
    t_log;
    t_setup;
    t_protect;
    t_cas;
    report_and_stop;
  end
endmodule

// File: test/dwac_props.sv
// Purpose: port checker for dwac_top
// Assumes: one clock, async active-low reset
// Notes: bound to the design top
`timescale 1ns/10ps
`include "dwac_defs.vh"
module dwac_props #(
  parameter [1:0] VARIANT = `DWAC_VAR_LARGEST
) (
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // Requests
  input wire ins_req, ins_we, ins_ext, dev_req, dev_we, dev_ext, protect_pin,
  input wire [`DWAC_AW-1:0] ins_addr, dev_addr,
  // Answers
  input wire ins_ack, ins_err, dev_ack, dev_err, cas_busy, cas_done
);
  localparam [12:0] FREE_LAST = (VARIANT == `DWAC_VAR_SMALL) ? `DWAC_FREE_SMALL_LAST :
    `DWAC_FREE_LARGE_LAST;
  wire iw = ins_req && ins_we && !ins_ext && !cas_busy;
  wire dw = dev_req && dev_we && !dev_ext && !cas_busy;
  wire i_ro = ins_addr >= `DWAC_RO_FIRST && ins_addr <= `DWAC_RO_LAST;
  wire d_ro = dev_addr >= `DWAC_RO_FIRST && dev_addr <= `DWAC_RO_LAST;
  wire i_log = ins_addr >= `DWAC_LOG_FIRST && ins_addr <= `DWAC_LOG_LAST;
  wire d_log = dev_addr >= `DWAC_LOG_FIRST && dev_addr <= `DWAC_LOG_LAST;
  wire i_set = ins_addr >= `DWAC_SETUP_FIRST && ins_addr <= `DWAC_SETUP_LAST;
  wire d_set = dev_addr >= `DWAC_SETUP_FIRST && dev_addr <= `DWAC_SETUP_LAST;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_ins_ack_taken: assert property (ins_req && !cas_busy |=> ins_ack)
    else $error("instruction request not answered");
  a_dev_ack_taken: assert property (dev_req && !cas_busy |=> dev_ack)
    else $error("device request not answered");
  a_err_with_ack: assert property ((ins_err |-> ins_ack) and (dev_err |-> dev_ack))
    else $error("refusal without answer");
  a_free_write_ok: assert property (iw && ins_addr <= FREE_LAST |=> !ins_err)
    else $error("free word write refused");
  a_ins_ro_refused: assert property (iw && i_ro |=> ins_err)
    else $error("instruction write to read-only word taken");
  a_dev_ro_open: assert property (!protect_pin [*4] ##0 dw && d_ro |=> !dev_err)
    else $error("unprotected device write refused");
  a_protect_refused: assert property (protect_pin [*4] ##0 dw && d_ro |=> dev_err)
    else $error("protected device write taken");
  a_log_no_write: assert property ((iw && i_log |=> ins_err) and (dw && d_log |=> dev_err))
    else $error("log word write taken");
  a_setup_rights: assert property ((iw && i_set |=> ins_err) and (dw && d_set |=> !dev_err))
    else $error("setup block rights wrong");
  a_ext_write_ok: assert property (ins_req && ins_we && ins_ext && !cas_busy &&
    VARIANT == `DWAC_VAR_LARGEST && ins_addr <= `DWAC_EXT_LAST |=> !ins_err)
    else $error("extended word write refused");
  a_busy_no_ack: assert property (cas_busy |=> !ins_ack && !dev_ack)
    else $error("request answered during transfer");
  a_save_ends: assert property ($rose(cas_busy) |-> ##[1:1000] cas_done)
    else $error("transfer did not finish");
  c_protect: cover property (protect_pin [*4] ##0 dw && d_ro);
  c_ext: cover property (ins_req && ins_ext && ins_we);
  c_done: cover property (cas_done);
endmodule
bind dwac_top dwac_props #(.VARIANT(VARIANT)) u_props (.core_clk(core_clk),
  .reset_n(reset_n), .ins_req(ins_req), .ins_we(ins_we), .ins_ext(ins_ext),
  .dev_req(dev_req), .dev_we(dev_we), .dev_ext(dev_ext), .protect_pin(protect_pin),
  .ins_addr(ins_addr), .dev_addr(dev_addr), .ins_ack(ins_ack), .ins_err(ins_err),
  .dev_ack(dev_ack), .dev_err(dev_err), .cas_busy(cas_busy), .cas_done(cas_done));

// File: test/dwac_req_model.sv
// Purpose: requester model, instruction side or programming device
// Assumes: request taken at one edge, answer one cycle later
// Notes: on release addr and wdata are inverted, while we and ext keep their old values
`timescale 1ns/10ps
module dwac_req_model (
  // Clock
  input wire core_clk,
  // Request
  output reg req, we, ext,
  output reg [12:0] addr,
  output reg [15:0] wdata,
  // Answer
  input wire ack, err,
  input wire [15:0] rdata
);
  initial begin
    {req, we, ext, addr, wdata} = 32'h0000_0000;
  end
  task acc(input logic w, x, input logic [12:0] a, input logic [15:0] d,
    output logic k, e, output logic [15:0] q);
    @(posedge core_clk);
    {req, we, ext, addr, wdata} <= {1'b1, w, x, a, d}; // Whole word
    @(posedge core_clk);
    {req, addr, wdata} <= {1'b0, ~a, ~d};
    #1;
    {k, e, q} = {ack, err, rdata};
  endtask
endmodule
